// ===== rtl/kah_port.sv
// host port of the keyboard/auxiliary device controller
`timescale 1ns/10ps
// Notes on behaviour
// - two independent serial channels, keyboard and auxiliary device.
// - each character is checked for odd parity before reaching host.
// - translate bit set in configuration converts keyboard scan codes.
// - each processed byte is readable as eight bits at port 60h.
// - interrupt on byte arrival, else byte held until polled.
// - reading port 64h returns the status byte.
// - writing port 64h is taken as a controller command.
// - translate set maps 12 set-2 codes to set 1, others unchanged, F0 is swallowed and sets bit 7 of the next code; cleared passes codes unchanged.
// - keyboard and auxiliary data each have their own interrupt enable.
// - port 60h writes go to keyboard unless a parameter is awaited.
module kah_port (
	// clock and reset
	input  wire logic               MCLK,
	input  wire logic               NRST,
	// host i/o bus
	input  wire logic [7:0]         ADDR,
	input  wire logic               RD,
	input  wire logic               WR,
	input  wire logic [7:0]         WDATA,
	output      logic [7:0]         RDATA,
	output      logic               IRQ_KBD,
	output      logic               IRQ_AUX,
	// deserialised characters from the two channels
	input  wire kah_pkg::kah_char_t KBD_CHAR,
	input  wire kah_pkg::kah_char_t AUX_CHAR,
	output      logic               KBD_ACCEPT,
	output      logic               AUX_ACCEPT,
	// bytes toward the keyboard, and channel inhibits
	output      logic [7:0]         KBD_TX_DATA,
	output      logic               KBD_TX_STB,
	output      logic               KBD_INHIBIT,
	output      logic               AUX_INHIBIT
);

	logic [7:0]          cfg_q, cfg_d;
	logic [7:0]          obuf_q, obuf_d;
	logic                obf_q, obf_d;
	logic                aux_q, aux_d;
	logic                perr_q, perr_d;
	logic                cmddat_q, cmddat_d;
	logic                irqk_q, irqk_d;
	logic                irqa_q, irqa_d;
	logic [7:0]          tx_q, tx_d;
	logic                txs_q, txs_d;
	kah_pkg::kah_state_t st_q, st_d;
	logic                f0_q, f0_d;

	logic                rd_data, wr_data, wr_cmd;
	logic                kbd_ok, aux_ok, kbd_perr, aux_perr;
	logic [7:0]          xl;
	logic [7:0]          status;

	assign rd_data = RD && (ADDR == kah_pkg::DATA_ADDR);
	assign wr_data = WR && (ADDR == kah_pkg::DATA_ADDR);
	assign wr_cmd  = WR && (ADDR == kah_pkg::CMDST_ADDR);

	// keyboard has priority; aux waits in its own deserialiser
	// a command write may load the buffer itself, so channels stall then
	assign kbd_ok = KBD_CHAR.valid && !obf_q && !wr_cmd
		&& !cfg_q[kah_pkg::CFG_KBD_DIS];
	assign aux_ok = AUX_CHAR.valid && !obf_q && !kbd_ok && !wr_cmd
		&& !cfg_q[kah_pkg::CFG_AUX_DIS];
	assign KBD_ACCEPT = kbd_ok;
	assign AUX_ACCEPT = aux_ok;
	// odd parity over data plus parity bit
	assign kbd_perr = ~^{KBD_CHAR.data, KBD_CHAR.parity};
	assign aux_perr = ~^{AUX_CHAR.data, AUX_CHAR.parity};

	// partial set-2 to set-1 map; break prefix sets bit 7
	always_comb
	begin
		case (KBD_CHAR.data)
			8'h1C:   xl = 8'h1E;
			8'h32:   xl = 8'h30;
			8'h21:   xl = 8'h2E;
			8'h23:   xl = 8'h20;
			8'h24:   xl = 8'h12;
			8'h5A:   xl = 8'h1C;
			8'h29:   xl = 8'h39;
			8'h76:   xl = 8'h01;
			8'h66:   xl = 8'h0E;
			8'h0D:   xl = 8'h0F;
			8'h12:   xl = 8'h2A;
			8'h14:   xl = 8'h1D;
			default: xl = KBD_CHAR.data;
		endcase
		if (f0_q)
			xl = xl | 8'h80;
	end

	always_comb
	begin
		status = 8'h00;
		status[kah_pkg::ST_OBF]     = obf_q;
		status[kah_pkg::ST_SYSFLAG] = cfg_q[kah_pkg::CFG_SYSFLAG];
		status[kah_pkg::ST_CMDDAT]  = cmddat_q;
		status[kah_pkg::ST_AUXOBF]  = obf_q && aux_q;
		status[kah_pkg::ST_PARERR]  = perr_q;
	end

	always_comb
	begin
		cfg_d    = cfg_q;
		obuf_d   = obuf_q;
		obf_d    = obf_q;
		aux_d    = aux_q;
		perr_d   = perr_q;
		cmddat_d = cmddat_q;
		irqk_d   = 1'b0;
		irqa_d   = 1'b0;
		tx_d     = tx_q;
		txs_d    = 1'b0;
		st_d     = st_q;
		f0_d     = f0_q;
		// data read frees the output buffer
		if (rd_data)
			obf_d = 1'b0;
		if (kbd_ok)
		begin
			// translate only when the config bit is set
			if (cfg_q[kah_pkg::CFG_XLATE] && KBD_CHAR.data == 8'hF0)
				f0_d = 1'b1;
			else
			begin
				f0_d   = 1'b0;
				obuf_d = cfg_q[kah_pkg::CFG_XLATE] ? xl : KBD_CHAR.data;
				obf_d  = 1'b1;
				aux_d  = 1'b0;
				perr_d = kbd_perr;
				irqk_d = cfg_q[kah_pkg::CFG_KBD_IEN];
			end
		end
		else if (aux_ok)
		begin
			obuf_d = AUX_CHAR.data;
			obf_d  = 1'b1;
			aux_d  = 1'b1;
			perr_d = aux_perr;
			irqa_d = cfg_q[kah_pkg::CFG_AUX_IEN];
		end
		if (wr_cmd)
		begin
			cmddat_d = 1'b1;
			st_d     = kah_pkg::ST_IDLE;
			case (WDATA)
				kah_pkg::CMD_RD_CFG:
				begin
					obuf_d = cfg_q;
					obf_d  = 1'b1;
					aux_d  = 1'b0;
				end
				kah_pkg::CMD_WR_CFG:  st_d = kah_pkg::ST_PARM;
				kah_pkg::CMD_AUX_DIS: cfg_d[kah_pkg::CFG_AUX_DIS] = 1'b1;
				kah_pkg::CMD_AUX_EN:  cfg_d[kah_pkg::CFG_AUX_DIS] = 1'b0;
				kah_pkg::CMD_KBD_DIS: cfg_d[kah_pkg::CFG_KBD_DIS] = 1'b1;
				kah_pkg::CMD_KBD_EN:  cfg_d[kah_pkg::CFG_KBD_DIS] = 1'b0;
				kah_pkg::CMD_SELFTST:
				begin
					obuf_d = kah_pkg::SELFTST_OK;
					obf_d  = 1'b1;
					aux_d  = 1'b0;
				end
				default: ;
			endcase
		end
		else if (wr_data)
		begin
			cmddat_d = 1'b0;
			case (st_q)
				kah_pkg::ST_PARM:
				begin
					cfg_d = WDATA & kah_pkg::CFG_WMASK;
					st_d  = kah_pkg::ST_IDLE;
				end
				default:
				begin
					tx_d  = WDATA;
					txs_d = 1'b1;
				end
			endcase
		end
	end

	always_ff @(posedge MCLK or negedge NRST)
	begin
		if (!NRST)
		begin
			cfg_q    <= kah_pkg::CFG_RESET;
			obuf_q   <= 8'h00;
			obf_q    <= 1'b0;
			aux_q    <= 1'b0;
			perr_q   <= 1'b0;
			cmddat_q <= 1'b0;
			irqk_q   <= 1'b0;
			irqa_q   <= 1'b0;
			tx_q     <= 8'h00;
			txs_q    <= 1'b0;
			st_q     <= kah_pkg::ST_IDLE;
			f0_q     <= 1'b0;
		end
		else
		begin
			cfg_q    <= cfg_d;
			obuf_q   <= obuf_d;
			obf_q    <= obf_d;
			aux_q    <= aux_d;
			perr_q   <= perr_d;
			cmddat_q <= cmddat_d;
			irqk_q   <= irqk_d;
			irqa_q   <= irqa_d;
			tx_q     <= tx_d;
			txs_q    <= txs_d;
			st_q     <= st_d;
			f0_q     <= f0_d;
		end
	end

	// status port returns the status byte, output buffer otherwise
	assign RDATA = (ADDR == kah_pkg::CMDST_ADDR) ? status : obuf_q;
	// one-cycle pulse; byte is held in obuf until read
	assign IRQ_KBD     = irqk_q;
	assign IRQ_AUX     = irqa_q;
	assign KBD_TX_DATA = tx_q;
	assign KBD_TX_STB  = txs_q;
	assign KBD_INHIBIT = cfg_q[kah_pkg::CFG_KBD_DIS];
	assign AUX_INHIBIT = cfg_q[kah_pkg::CFG_AUX_DIS];

	property p_rd_clear;
		@(posedge MCLK) disable iff (!NRST)
		(rd_data && !KBD_CHAR.valid && !AUX_CHAR.valid && !wr_cmd)
			|=> !obf_q;
	endproperty
	a_rd_clear: assert property (p_rd_clear)
		else $error("data read did not clear full flag");

	// a full buffer is never overwritten by channel data
	property p_hold;
		@(posedge MCLK) disable iff (!NRST)
		(obf_q && !rd_data && !wr_cmd) |=> $stable(obuf_q);
	endproperty
	a_hold: assert property (p_hold)
		else $error("held byte changed before read");

	property p_kirq;
		@(posedge MCLK) disable iff (!NRST)
		IRQ_KBD |-> $past(cfg_q[kah_pkg::CFG_KBD_IEN]) && obf_q;
	endproperty
	a_kirq: assert property (p_kirq)
		else $error("keyboard irq without enable");

	// data write forwards byte when idle
	property p_fwd;
		@(posedge MCLK) disable iff (!NRST)
		(wr_data && st_q == kah_pkg::ST_IDLE) |=>
			KBD_TX_STB && KBD_TX_DATA == $past(WDATA);
	endproperty
	a_fwd: assert property (p_fwd)
		else $error("data byte not forwarded");

	// aux interrupt only with its enable
	property p_airq;
		@(posedge MCLK) disable iff (!NRST)
		IRQ_AUX |-> $past(cfg_q[kah_pkg::CFG_AUX_IEN]) && obf_q && aux_q;
	endproperty
	a_airq: assert property (p_airq)
		else $error("aux irq without enable");

	// no character taken over a full buffer
	property p_refuse;
		@(posedge MCLK) disable iff (!NRST)
		obf_q |-> !KBD_ACCEPT && !AUX_ACCEPT;
	endproperty
	a_refuse: assert property (p_refuse)
		else $error("character accepted into full buffer");

	property p_cmd_local;
		@(posedge MCLK) disable iff (!NRST)
		wr_cmd |=> !KBD_TX_STB;
	endproperty
	a_cmd_local: assert property (p_cmd_local)
		else $error("command byte forwarded to keyboard");

endmodule : kah_port

// ===== rtl/kah_pkg.sv
// shared constants and types for the keyboard/aux host port
package kah_pkg;

	// i/o port addresses
	localparam logic [7:0] DATA_ADDR   = 8'h60;
	localparam logic [7:0] CMDST_ADDR  = 8'h64;

	// configuration byte fields
	localparam int CFG_KBD_IEN  = 0;
	localparam int CFG_AUX_IEN  = 1;
	localparam int CFG_SYSFLAG  = 2;
	localparam int CFG_KBD_DIS  = 4;
	localparam int CFG_AUX_DIS  = 5;
	localparam int CFG_XLATE    = 6;
	localparam logic [7:0] CFG_RESET   = 8'h03;
	localparam logic [7:0] CFG_WMASK   = 8'h77;

	// status byte fields
	localparam int ST_OBF     = 0;
	localparam int ST_IBF     = 1;
	localparam int ST_SYSFLAG = 2;
	localparam int ST_CMDDAT  = 3;
	localparam int ST_AUXOBF  = 5;
	localparam int ST_PARERR  = 7;

	// controller commands
	localparam logic [7:0] CMD_RD_CFG  = 8'h20;
	localparam logic [7:0] CMD_WR_CFG  = 8'h60;
	localparam logic [7:0] CMD_AUX_DIS = 8'hA7;
	localparam logic [7:0] CMD_AUX_EN  = 8'hA8;
	localparam logic [7:0] CMD_SELFTST = 8'hAA;
	localparam logic [7:0] CMD_KBD_DIS = 8'hAD;
	localparam logic [7:0] CMD_KBD_EN  = 8'hAE;
	localparam logic [7:0] SELFTST_OK  = 8'h55;

	// one received character from a serial channel
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
		logic       parity;
	} kah_char_t;

	typedef enum logic [0:0] {
		ST_IDLE = 1'b0,
		ST_PARM = 1'b1
	} kah_state_t;

endpackage : kah_pkg

// ===== tb/kah_chan_src.sv
// character source standing in for one serial channel
`timescale 1ns/10ps
module kah_chan_src (
	// clock
	input  wire logic               MCLK,
	// handshake and character toward the port
	input  wire logic               ACCEPT,
	output      kah_pkg::kah_char_t CH
);
	initial CH = '0;
	task automatic send(input logic [7:0] b, input logic bad);
		@(negedge MCLK);
		CH = {1'b1, b, ~^b ^ bad};
		// accept is looked at on the edge that takes the character
		@(posedge MCLK);
		while (ACCEPT !== 1'b1)
			@(posedge MCLK);
		@(negedge MCLK);
		// released lines show the inverse so stale data cannot pass
		CH = {1'b0, ~b, 1'b0};
	endtask : send
endmodule : kah_chan_src

// ===== tb/kah_port_tb_top.sv
// self-checking bench for the keyboard/aux host port
`timescale 1ns/10ps
module kah_port_tb_top;
	logic               mclk, nrst, rd, wr, irq_k, irq_a;
	logic               acc_k, acc_a, stb, inh_k, inh_a;
	logic [7:0]         addr, wdata, rdata, txd, v, tx_last;
	kah_pkg::kah_char_t kch, ach;
	int                 n_fail = 0, compares = 0;
	int                 n_irqk = 0, n_irqa = 0, n_tx = 0;

	kah_port dut (.MCLK(mclk), .NRST(nrst), .ADDR(addr), .RD(rd),
		.WR(wr), .WDATA(wdata), .RDATA(rdata), .IRQ_KBD(irq_k),
		.IRQ_AUX(irq_a), .KBD_CHAR(kch), .AUX_CHAR(ach),
		.KBD_ACCEPT(acc_k), .AUX_ACCEPT(acc_a), .KBD_TX_DATA(txd),
		.KBD_TX_STB(stb), .KBD_INHIBIT(inh_k), .AUX_INHIBIT(inh_a));
	kah_chan_src src_k (.MCLK(mclk), .ACCEPT(acc_k), .CH(kch));
	kah_chan_src src_a (.MCLK(mclk), .ACCEPT(acc_a), .CH(ach));

	initial
	begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end

	always @(posedge mclk)
	begin
		n_irqk += (irq_k === 1'b1);
		n_irqa += (irq_a === 1'b1);
		n_tx += (stb === 1'b1);
		if (stb === 1'b1)
			tx_last = txd;
	end

	task automatic check(input string what, input logic [7:0] seen, exp);
		compares++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("mismatch %s expected %h seen %h", what, exp, seen);
		end
	endtask : check

	// one host access: held until the sampling edge, answer taken there
	task automatic acc(input logic [7:0] a, input logic w, input logic [7:0] d);
		@(negedge mclk);
		addr = a;
		rd = ~w;
		wr = w;
		wdata = d;
		@(posedge mclk);
		v = rdata;
		@(negedge mclk);
		rd = 1'b0;
		wr = 1'b0;
	endtask : acc

	task automatic summarize;
		$display("compares %0d n_fail %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize

	// a full run takes well under 1000 cycles
	initial
	begin
		#100us;
		n_fail++;
		summarize();
	end

	initial
	begin
		nrst = 1'b0;
		rd = 1'b0;
		wr = 1'b0;
		addr = 8'h00;
		wdata = 8'h00;
		repeat (4) @(posedge mclk);
		@(negedge mclk);
		nrst = 1'b1;
		acc(kah_pkg::CMDST_ADDR, 1'b0, 8'h00);
		check("status", v & 8'h23, 8'h00);
		check("ibf", v[kah_pkg::ST_IBF], 8'h00);
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_RD_CFG);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("cfg", v, kah_pkg::CFG_RESET);
		$display("test reset done");
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_WR_CFG);
		acc(kah_pkg::DATA_ADDR, 1'b1, 8'h01);
		n_irqk = 0;
		n_tx = 0;
		src_k.send(8'h1C, 1'b0);
		repeat (3) @(negedge mclk);
		acc(kah_pkg::CMDST_ADDR, 1'b0, 8'h00);
		check("obf", v[kah_pkg::ST_OBF], 8'h01);
		check("irq kbd", 8'(n_irqk), 8'h01);
		check("cfg not sent", 8'(n_tx), 8'h00);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("kbd byte", v, 8'h1C);
		acc(kah_pkg::CMDST_ADDR, 1'b0, 8'h00);
		check("obf clear", v[kah_pkg::ST_OBF], 8'h00);
		$display("test keyboard done");
		n_irqa = 0;
		src_a.send(8'h5A, 1'b0);
		repeat (3) @(negedge mclk);
		acc(kah_pkg::CMDST_ADDR, 1'b0, 8'h00);
		check("aux obf", v[kah_pkg::ST_AUXOBF], 8'h01);
		check("irq aux", 8'(n_irqa), 8'h00);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("aux byte", v, 8'h5A);
		src_k.send(8'h33, 1'b1);
		repeat (3) @(negedge mclk);
		acc(kah_pkg::CMDST_ADDR, 1'b0, 8'h00);
		check("parity err", v[kah_pkg::ST_PARERR], 8'h01);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		$display("test aux and parity done");
		acc(kah_pkg::DATA_ADDR, 1'b1, 8'hED);
		repeat (2) @(negedge mclk);
		check("tx count", 8'(n_tx), 8'h01);
		check("tx byte", tx_last, 8'hED);
		acc(kah_pkg::CMDST_ADDR, 1'b0, 8'h00);
		check("data flag", v[kah_pkg::ST_CMDDAT], 8'h00);
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_KBD_DIS);
		repeat (2) @(negedge mclk);
		check("kbd inhibit", inh_k, 8'h01);
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_KBD_EN);
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_WR_CFG);
		acc(kah_pkg::DATA_ADDR, 1'b1, 8'h41);
		src_k.send(8'hF0, 1'b0);
		repeat (3) @(negedge mclk);
		acc(kah_pkg::CMDST_ADDR, 1'b0, 8'h00);
		check("prefix held", v[kah_pkg::ST_OBF], 8'h00);
		src_k.send(8'h1C, 1'b0);
		repeat (3) @(negedge mclk);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("xlate break", v, 8'h9E);
		src_k.send(8'h5A, 1'b0);
		repeat (3) @(negedge mclk);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("xlate make", v, 8'h1C);
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_SELFTST);
		acc(kah_pkg::CMDST_ADDR, 1'b0, 8'h00);
		check("cmd flag", v[kah_pkg::ST_CMDDAT], 8'h01);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("self test", v, kah_pkg::SELFTST_OK);
		$display("test commands done");
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_WR_CFG);
		acc(kah_pkg::DATA_ADDR, 1'b1, 8'h02);
		n_irqa = 0;
		src_a.send(8'h77, 1'b0);
		repeat (3) @(negedge mclk);
		check("irq aux on", 8'(n_irqa), 8'h01);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("aux byte 2", v, 8'h77);
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_AUX_DIS);
		repeat (2) @(negedge mclk);
		check("aux inhibit", inh_a, 8'h01);
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_AUX_EN);
		repeat (2) @(negedge mclk);
		check("aux release", inh_a, 8'h00);
		fork
			src_k.send(8'h11, 1'b0);
			src_a.send(8'h22, 1'b0);
		join_any
		repeat (2) @(negedge mclk);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("kbd first", v, 8'h11);
		wait fork;
		repeat (2) @(negedge mclk);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("aux second", v, 8'h22);
		$display("test aux irq and priority done");
		@(negedge mclk);
		nrst = 1'b0;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		acc(kah_pkg::CMDST_ADDR, 1'b1, kah_pkg::CMD_RD_CFG);
		acc(kah_pkg::DATA_ADDR, 1'b0, 8'h00);
		check("cfg after reset", v, kah_pkg::CFG_RESET);
		$display("test mid reset done");
		summarize();
	end
endmodule : kah_port_tb_top
